/* dv/enc_model.sv */
`timescale 1ns/1ps
module enc_model (
  input  wire logic clk,
  output logic      pha,
  output logic      phb,
  output logic      pre
);
  initial begin
    pha = 1'b0;
    phb = 1'b0;
    pre = 1'b0;
  end
  // Every level is held four clocks
  task automatic hold(input logic a, input logic b, input logic p);
    pha <= a;
    phb <= b;
    pre <= p;
    repeat (4) @(posedge clk);
  endtask
  // Count pulse on A only, B settled before A rises
  task automatic pulse(input logic b);
    hold(1'b0, b, 1'b0);
    hold(1'b1, b, 1'b0);
    hold(1'b0, b, 1'b0);
  endtask
  // Full cycle, A leads B when counting up
  task automatic quad(input logic up);
    hold(up, !up, 1'b0);
    hold(1'b1, 1'b1, 1'b0);
    hold(!up, up, 1'b0);
    hold(1'b0, 1'b0, 1'b0);
  endtask
  task automatic preset();
    hold(1'b0, 1'b0, 1'b1);
    hold(1'b0, 1'b0, 1'b0);
  endtask
endmodule

/* dv/qpc_props.sv */
`timescale 1ns/1ps
module qpc_props
  import qpc_pkg::*;
(
  input wire logic        SYS_CLK,
  input wire logic        RST,
  input wire logic        PHASE_A,
  input wire logic        PHASE_B,
  input wire logic        HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0]  HTRANS,
  input wire logic        HWRITE,
  input wire logic [31:0] HWDATA,
  input wire logic        HREADY,
  input wire logic [31:0] HRDATA,
  input wire logic        HREADYOUT,
  input wire logic        HRESP
);
  default clocking @(posedge SYS_CLK); endclocking
  default disable iff (RST);
  logic       rd_q;
  logic       wr_q;
  logic       en;
  logic [7:0] a_q;
  logic [2:0] idle;
  wire        take = HSEL && HREADY && HTRANS[1];
  always_ff @(posedge SYS_CLK) begin
    rd_q <= !RST && take && !HWRITE;
    wr_q <= !RST && take && HWRITE;
  end
  always_ff @(posedge SYS_CLK) begin
    if (take) a_q <= HADDR[7:0];
  end
  always_ff @(posedge SYS_CLK) begin
    if (RST) en <= 1'b0;
    else if (wr_q && a_q == ADDR_CONFIG) en <= HWDATA[CFG_ENABLE_BIT];
  end
  // Cycles since the count was disabled, saturating
  always_ff @(posedge SYS_CLK) begin
    if (RST || en) idle <= 3'h0;
    else if (idle != 3'h7) idle <= idle + 3'h1;
  end
  sequence s_a_quiet;
    $stable(PHASE_A)[*6];
  endsequence
  sequence s_b_quiet;
    $stable(PHASE_B)[*6];
  endsequence
  sequence s_stat_rd;
    rd_q && a_q == ADDR_STATUS;
  endsequence
  a_no_wait: assert property (HREADYOUT)
    else $error("slave inserted a wait state");
  a_resp_okay: assert property (!HRESP)
    else $error("slave gave an error response");
  a_read_hold: assert property (!rd_q |-> $stable(HRDATA))
    else $error("read data moved outside a read");
  a_count_width: assert property (rd_q && a_q == ADDR_COUNT |-> HRDATA[31:CNT_W] == '0)
    else $error("count upper bits not zero");
  a_unmapped_zero: assert property (rd_q && a_q > ADDR_STATUS |-> HRDATA == 32'h0)
    else $error("unmapped read not zero");
  a_level_a: assert property (s_a_quiet ##0 s_stat_rd |-> HRDATA[0] == PHASE_A)
    else $error("status A level wrong");
  a_level_b: assert property (s_b_quiet ##0 s_stat_rd |-> HRDATA[1] == PHASE_B)
    else $error("status B level wrong");
  a_disabled_zero: assert property (rd_q && a_q == ADDR_COUNT && idle == 3'h7
    |-> HRDATA[CNT_W-1:0] == CNT_ZERO) else $error("disabled count not zero");
endmodule

/* dv/quadrature_pulse_counter_tb.sv */
`timescale 1ns/1ps
module quadrature_pulse_counter_tb
  import qpc_pkg::*;
;
  logic        SYS_CLK = 1'b0;
  logic        RST = 1'b1;
  logic        HSEL;
  logic [31:0] HADDR;
  logic [1:0]  HTRANS;
  logic        HWRITE;
  logic [2:0]  HSIZE;
  logic [31:0] HWDATA;
  logic [31:0] HRDATA;
  logic        HREADYOUT;
  logic        HRESP;
  logic        pha;
  logic        phb;
  logic        pre;
  int          n_fail = 0;
  int          checked = 0;
  always #4 SYS_CLK = ~SYS_CLK;
  enc_model enc_model_inst (.clk(SYS_CLK), .pha(pha), .phb(phb), .pre(pre));
  quadrature_pulse_counter quadrature_pulse_counter_inst (
    .SYS_CLK(SYS_CLK), .RST(RST), .PHASE_A(pha), .PHASE_B(phb), .PRESET_PIN(pre),
    .HSEL(HSEL), .HADDR(HADDR), .HTRANS(HTRANS), .HWRITE(HWRITE), .HSIZE(HSIZE),
    .HWDATA(HWDATA), .HREADY(HREADYOUT), .HRDATA(HRDATA), .HREADYOUT(HREADYOUT),
    .HRESP(HRESP));
  task automatic wrap_up();
    $display("checked %0d n_fail %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] rd);
    int k;
    HSEL <= 1'b1;
    HTRANS <= HTRANS_NONSEQ;
    HADDR <= {24'h0, a};
    HWRITE <= w;
    HSIZE <= 3'h2;
    for (int ph = 0; ph < 2; ph++) begin
      k = 0;
      do begin
        @(posedge SYS_CLK);
        k++;
      end while (HREADYOUT !== 1'b1 && k < 20);
      if (HREADYOUT !== 1'b1) begin
        n_fail++;
        wrap_up();
      end
      if (ph == 0) begin
        HSEL <= 1'b0;
        HTRANS <= 2'h0;
        HWDATA <= wd;
      end
    end
    rd = HRDATA;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] x;
    ahb(1'b1, a, d, x);
  endtask
  task automatic rd_chk(input string s, input logic [7:0] a, input logic [31:0] e,
                        input logic [31:0] m);
    logic [31:0] d;
    repeat (6) @(posedge SYS_CLK);
    ahb(1'b0, a, 32'h0, d);
    checked++;
    if ((d & m) !== e) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", s, e, d & m);
    end
  endtask
  task automatic t_reset();
    rd_chk("config", ADDR_CONFIG, 32'h100, '1);
    rd_chk("unmapped", 8'h14, 32'h0, '1);
    rd_chk("count", ADDR_COUNT, 32'h0, '1);
    $display("test reset done");
  endtask
  task automatic t_one_phase();
    wr(ADDR_CONFIG, 32'h408);
    repeat (5) enc_model_inst.pulse(1'b0);
    rd_chk("up count", ADDR_COUNT, 32'h5, '1);
    wr(ADDR_CONFIG, 32'h40c);
    repeat (2) enc_model_inst.pulse(1'b0);
    rd_chk("down count", ADDR_COUNT, 32'h3, '1);
    rd_chk("direction", ADDR_STATUS, 32'h4, 32'h4);
    $display("test one phase done");
  endtask
  task automatic t_dir_b();
    wr(ADDR_CONFIG, 32'h10e);
    repeat (3) enc_model_inst.pulse(1'b1);
    rd_chk("levels", ADDR_STATUS, 32'h2, 32'h3);
    repeat (2) enc_model_inst.pulse(1'b0);
    rd_chk("b direction", ADDR_COUNT, 32'h4, '1);
    $display("test b direction done");
  endtask
  task automatic t_quad();
    logic [2:0] m;
    logic [2:0] old_m;
    for (int i = 0; i < 3; i++) begin
      m = 3'h1 << i;
      old_m = (i == 0) ? 3'h1 : (m >> 1);
      wr(ADDR_CONFIG, 32'h0);
      rd_chk("kept edge_multiplier", ADDR_CONFIG, {21'h0, old_m, 8'h00}, '1);
      rd_chk("cleared", ADDR_COUNT, 32'h0, '1);
      wr(ADDR_CONFIG, {21'h0, m, 8'h09});
      repeat (2) enc_model_inst.quad(1'b1);
      rd_chk("quad up", ADDR_COUNT, {29'h0, m} * 2, '1);
      enc_model_inst.quad(1'b0);
      rd_chk("quad down", ADDR_COUNT, {29'h0, m}, '1);
    end
    $display("test quadrature done");
  endtask
  task automatic t_preset();
    wr(ADDR_PRESET, 32'hffffff);
    wr(ADDR_CONFIG, 32'h108);
    wr(ADDR_CONTROL, 32'h1);
    rd_chk("sw preset", ADDR_COUNT, 32'hffffff, '1);
    enc_model_inst.pulse(1'b0);
    rd_chk("wrap", ADDR_COUNT, 32'h0, '1);
    wr(ADDR_CONTROL, 32'h0);
    wr(ADDR_CONFIG, 32'h118);
    wr(ADDR_CONTROL, 32'h1);
    rd_chk("sw ignored", ADDR_COUNT, 32'h0, '1);
    enc_model_inst.preset();
    rd_chk("pin preset", ADDR_COUNT, 32'hffffff, '1);
    $display("test preset done");
  endtask
  initial begin
    HSEL <= 1'b0;
    HADDR <= 32'h0;
    HTRANS <= 2'h0;
    HWRITE <= 1'b0;
    HSIZE <= 3'h0;
    HWDATA <= 32'h0;
    repeat (10) @(posedge SYS_CLK);
    RST <= 1'b0;
    t_reset();
    t_one_phase();
    t_dir_b();
    t_quad();
    t_preset();
    wrap_up();
  end
endmodule
bind quadrature_pulse_counter qpc_props qpc_props_inst (
  .SYS_CLK(SYS_CLK), .RST(RST), .PHASE_A(PHASE_A), .PHASE_B(PHASE_B), .HSEL(HSEL),
  .HADDR(HADDR), .HTRANS(HTRANS), .HWRITE(HWRITE), .HWDATA(HWDATA), .HREADY(HREADY),
  .HRDATA(HRDATA), .HREADYOUT(HREADYOUT), .HRESP(HRESP));

/* src/count_step_decode.sv */
`timescale 1ns/1ps
module count_step_decode
  import qpc_pkg::*;
(
  input  counter_cfg_s cfg,
  input  pin_events_s  ev,
  output logic         step,
  output logic         down
);
  always_comb begin
    step = 1'b0;
    down = 1'b0;
    if (cfg.phase_mode_select == PHASE_ONE) begin
      step = ev.rise_a;
      if (cfg.dir_from_b) begin
        down = ~ev.level_b;
      end else begin
        down = cfg.down;
      end
    end else begin
      // B lagging A by a quarter cycle means up: on A rising, B low
      unique case (cfg.edge_multiplier)
        EDGE_MULTIPLIER_X2: begin
          step = ev.rise_a | ev.fall_a;
        end
        EDGE_MULTIPLIER_X4: begin
          step = ev.rise_a | ev.fall_a | ev.rise_b | ev.fall_b;
        end
        default: begin
          step = ev.rise_a;
        end
      endcase
      if (ev.rise_a | ev.fall_a) begin
        down = ev.level_a ^ ~ev.level_b;
      end else begin
        down = ev.level_a ^ ev.level_b;
      end
    end
  end
endmodule

/* src/pin_edge_sync.sv */
`timescale 1ns/1ps
module pin_edge_sync
  import qpc_pkg::*;
(
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic pin,
  output logic      level,
  output logic      rise,
  output logic      fall
);
  logic [2:0] stage;

  always_ff @(posedge clk) begin
    if (rst) begin
      stage <= 3'h0;
    end else begin
      stage <= {stage[1:0], pin};
    end
  end

  // A change is accepted once stages two and three agree
  always_ff @(posedge clk) begin
    if (rst) begin
      level <= 1'b0;
      rise  <= 1'b0;
      fall  <= 1'b0;
    end else begin
      rise <= 1'b0;
      fall <= 1'b0;
      if (stage[1] == stage[2] && stage[2] != level) begin
        level <= stage[2];
        rise  <= stage[2];
        fall  <= ~stage[2];
      end
    end
  end
endmodule

/* src/qpc_pkg.sv */
package qpc_pkg;
  localparam int  CNT_W            = 24;
  localparam int  DATA_W           = 32;
  localparam int  ADDR_W           = 8;
  // Register byte addresses
  localparam logic [ADDR_W-1:0] ADDR_CONFIG = 8'h00;
  localparam logic [ADDR_W-1:0] ADDR_CONTROL = 8'h04;
  localparam logic [ADDR_W-1:0] ADDR_PRESET = 8'h08;
  localparam logic [ADDR_W-1:0] ADDR_COUNT = 8'h0c;
  localparam logic [ADDR_W-1:0] ADDR_STATUS = 8'h10;
  // Config and control field positions
  localparam int  CFG_PHASE_BIT    = 0;
  localparam int  CFG_DIRSRC_BIT   = 1;
  localparam int  CFG_DOWN_BIT     = 2;
  localparam int  CFG_ENABLE_BIT   = 3;
  localparam int  CFG_PRESRC_BIT   = 4;
  localparam int  CFG_EDGE_MULTIPLIER_LO      = 8;
  localparam int  CFG_EDGE_MULTIPLIER_HI      = 10;
  localparam int  CTL_PRESET_BIT   = 0;
  // Edge multiplier encodings
  localparam logic [2:0] EDGE_MULTIPLIER_X1   = 3'h1;
  localparam logic [2:0] EDGE_MULTIPLIER_X2   = 3'h2;
  localparam logic [2:0] EDGE_MULTIPLIER_X4   = 3'h4;
  localparam logic [CNT_W-1:0] CNT_ONE  = 24'h000001;
  localparam logic [CNT_W-1:0] CNT_ZERO = 24'h000000;
  localparam logic [1:0]  HTRANS_NONSEQ = 2'h2;
  localparam logic [1:0]  HTRANS_SEQ    = 2'h3;

  typedef enum logic [0:0] {
    PHASE_ONE = 1'b0,
    PHASE_TWO = 1'b1
  } phase_mode_select_e;

  typedef struct packed {
    logic               count_enable;
    phase_mode_select_e phase_mode_select;
    logic               dir_from_b;
    logic               down;
    logic               preset_external;
    logic [2:0]         edge_multiplier;
  } counter_cfg_s;

  typedef struct packed {
    logic rise_a;
    logic fall_a;
    logic rise_b;
    logic fall_b;
    logic level_a;
    logic level_b;
    logic rise_preset;
  } pin_events_s;
endpackage

/* src/quadrature_pulse_counter.sv */
// Our own choices: the AHB-Lite interface to the registers and the register addresses.
`timescale 1ns/1ps
module quadrature_pulse_counter
  import qpc_pkg::*;
(
  input  wire logic              SYS_CLK,
  input  wire logic              RST,
  input  wire logic              PHASE_A,
  input  wire logic              PHASE_B,
  input  wire logic              PRESET_PIN,
  input  wire logic              HSEL,
  input  wire logic [31:0]       HADDR,
  input  wire logic [1:0]        HTRANS,
  input  wire logic              HWRITE,
  input  wire logic [2:0]        HSIZE,
  input  wire logic [DATA_W-1:0] HWDATA,
  input  wire logic              HREADY,
  output logic      [DATA_W-1:0] HRDATA,
  output logic                   HREADYOUT,
  output logic                   HRESP
);
  counter_cfg_s     cfg;
  logic [CNT_W-1:0] preset_value;
  logic [CNT_W-1:0] count;
  logic             preset_req;
  logic             preset_req_d;
  logic             preset_seen;
  pin_events_s      ev;
  logic             step;
  logic             down;
  logic             wr_pend;
  logic [ADDR_W-1:0] wr_addr;
  logic             access;
  logic [DATA_W-1:0] next_rdata;

  pin_edge_sync sync_a (
    .clk   (SYS_CLK),
    .rst   (RST),
    .pin   (PHASE_A),
    .level (ev.level_a),
    .rise  (ev.rise_a),
    .fall  (ev.fall_a)
  );

  pin_edge_sync sync_b (
    .clk   (SYS_CLK),
    .rst   (RST),
    .pin   (PHASE_B),
    .level (ev.level_b),
    .rise  (ev.rise_b),
    .fall  (ev.fall_b)
  );

  pin_edge_sync sync_p (
    .clk   (SYS_CLK),
    .rst   (RST),
    .pin   (PRESET_PIN),
    .level (),
    .rise  (ev.rise_preset),
    .fall  ()
  );

  count_step_decode decode (
    .cfg  (cfg),
    .ev   (ev),
    .step (step),
    .down (down)
  );

  assign access = HSEL & HREADY & (HTRANS == HTRANS_NONSEQ || HTRANS == HTRANS_SEQ);

  // Bus address phase capture for writes
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      wr_pend <= 1'b0;
      wr_addr <= '0;
    end else begin
      wr_pend <= access & HWRITE;
      wr_addr <= HADDR[ADDR_W-1:0];
    end
  end

  // Configuration register
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      cfg <= '{count_enable: 1'b0, phase_mode_select: PHASE_ONE, dir_from_b: 1'b0,
               down: 1'b0, preset_external: 1'b0, edge_multiplier: EDGE_MULTIPLIER_X1};
    end else if (wr_pend && wr_addr == ADDR_CONFIG) begin
      cfg.phase_mode_select <= phase_mode_select_e'(HWDATA[CFG_PHASE_BIT]);
      cfg.dir_from_b        <= HWDATA[CFG_DIRSRC_BIT];
      cfg.down              <= HWDATA[CFG_DOWN_BIT];
      cfg.count_enable      <= HWDATA[CFG_ENABLE_BIT];
      cfg.preset_external   <= HWDATA[CFG_PRESRC_BIT];
      // Illegal multipliers are kept out so only 1, 2 or 4 is stored
      if (HWDATA[CFG_EDGE_MULTIPLIER_HI:CFG_EDGE_MULTIPLIER_LO] == EDGE_MULTIPLIER_X1 ||
          HWDATA[CFG_EDGE_MULTIPLIER_HI:CFG_EDGE_MULTIPLIER_LO] == EDGE_MULTIPLIER_X2 ||
          HWDATA[CFG_EDGE_MULTIPLIER_HI:CFG_EDGE_MULTIPLIER_LO] == EDGE_MULTIPLIER_X4) begin
        cfg.edge_multiplier <= HWDATA[CFG_EDGE_MULTIPLIER_HI:CFG_EDGE_MULTIPLIER_LO];
      end
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      preset_value <= CNT_ZERO;
    end else if (wr_pend && wr_addr == ADDR_PRESET) begin
      preset_value <= HWDATA[CNT_W-1:0];
    end
  end

  // Software preset request level; its rising edge acts
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      preset_req   <= 1'b0;
      preset_req_d <= 1'b0;
    end else begin
      if (wr_pend && wr_addr == ADDR_CONTROL) begin
        preset_req <= HWDATA[CTL_PRESET_BIT];
      end
      preset_req_d <= preset_req;
    end
  end

  always_comb begin
    if (cfg.preset_external) begin
      preset_seen = ev.rise_preset;
    end else begin
      preset_seen = preset_req & ~preset_req_d;
    end
  end

  // Counter core; preset beats a simultaneous count step
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      count <= CNT_ZERO;
    end else if (!cfg.count_enable) begin
      count <= CNT_ZERO;
    end else if (preset_seen) begin
      count <= preset_value;
    end else if (step) begin
      if (down) begin
        count <= count - CNT_ONE;
      end else begin
        count <= count + CNT_ONE;
      end
    end
  end

  always_comb begin
    next_rdata = '0;
    unique case (HADDR[ADDR_W-1:0])
      ADDR_CONFIG: begin
        next_rdata[CFG_PHASE_BIT]          = cfg.phase_mode_select;
        next_rdata[CFG_DIRSRC_BIT]         = cfg.dir_from_b;
        next_rdata[CFG_DOWN_BIT]           = cfg.down;
        next_rdata[CFG_ENABLE_BIT]         = cfg.count_enable;
        next_rdata[CFG_PRESRC_BIT]         = cfg.preset_external;
        next_rdata[CFG_EDGE_MULTIPLIER_HI:CFG_EDGE_MULTIPLIER_LO] = cfg.edge_multiplier;
      end
      ADDR_CONTROL: next_rdata[CTL_PRESET_BIT] = preset_req;
      ADDR_PRESET:  next_rdata[CNT_W-1:0]      = preset_value;
      ADDR_COUNT:   next_rdata[CNT_W-1:0]      = count;
      ADDR_STATUS: begin
        next_rdata[0] = ev.level_a;
        next_rdata[1] = ev.level_b;
        next_rdata[2] = down;
      end
      default:      next_rdata = '0;
    endcase
  end

  // Read data registered in the data phase; zero-wait slave, always OKAY
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      HRDATA    <= '0;
      HREADYOUT <= 1'b1;
      HRESP     <= 1'b0;
    end else begin
      HREADYOUT <= 1'b1;
      HRESP     <= 1'b0;
      if (access && !HWRITE) begin
        HRDATA <= next_rdata;
      end
    end
  end
endmodule
